// *** logic/wit_pkg.sv ***
`default_nettype none
package wit_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [27:0] CTRL_ADDR = 28'hfff_f680;
	localparam logic [27:0] STATUS_ADDR = 28'hfff_f684;
	localparam logic [27:0] MASK_ADDR = 28'hfff_f688;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int EN_BIT = 0;
	localparam int RUN_BIT = 1;
	localparam int FLAG_LSB = 2;
	localparam int IVL_LSB = 4;
	localparam int SRC_BIT = 7;

	// Status and mask bit positions
	localparam int IRQ_WATCH = 0;
	localparam int IRQ_IVL = 1;

	// ----------------------------------------------------------------
	// Counter widths and reset values
	// ----------------------------------------------------------------
	localparam int PRESCALE_W = 11;
	localparam int COUNT_W = 5;
	localparam logic [10:0] PRESCALE_RESET = 11'h000;
	localparam logic [10:0] PRESCALE_FULL = 11'h7ff;
	localparam logic [4:0] COUNT_RESET = 5'h00;
	localparam logic [2:0] SYNC_RESET = 3'h0;

	typedef enum logic [1:0] {
		FLAG_2P14 = 2'h0,
		FLAG_2P13 = 2'h1,
		FLAG_2P5 = 2'h2,
		FLAG_2P4 = 2'h3
	} flag_period_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'h1,
		BUS_ACK = 2'h2
	} bus_state_t;
endpackage
`default_nettype wire

// *** logic/irq_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface irq_if;
	logic [1:0] event_p;
	logic wr_status;
	logic wr_mask;
	logic [1:0] wdata;
	logic [1:0] status;
	logic [1:0] mask;
	logic irq;
	modport core (output event_p, output wr_status, output wr_mask, output wdata,
		input status, input mask, input irq);
	modport ctl (input event_p, input wr_status, input wr_mask, input wdata,
		output status, output mask, output irq);
endinterface
`default_nettype wire

// *** logic/edge_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic rise
);
	logic [2:0] sync;
	logic [2:0] next_sync;

	// Stage 0 is only read by stage 1; the edge looks at stages 1 and 2
	always_comb begin
		next_sync = {sync[1:0], async_in};
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync <= wit_pkg::SYNC_RESET;
		end else begin
			sync <= next_sync;
		end
	end

	assign rise = sync[1] & ~sync[2];
endmodule
`default_nettype wire

// *** logic/irq_ctl.sv ***
`timescale 1ns/10ps
`default_nettype none
module irq_ctl (
	input wire logic core_clk,
	input wire logic rst_n,
	irq_if.ctl bus
);
	logic [1:0] next_status;
	logic [1:0] next_mask;

	// A new event wins over a write-one-to-clear in the same cycle
	always_comb begin
		next_status = bus.status;
		if (bus.wr_status) begin
			next_status = bus.status & ~bus.wdata;
		end
		next_status = next_status | bus.event_p;
		next_mask = bus.wr_mask ? bus.wdata : bus.mask;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bus.status <= wit_pkg::IRQ_RESET;
			bus.mask <= wit_pkg::IRQ_RESET;
		end else begin
			bus.status <= next_status;
			bus.mask <= next_mask;
		end
	end

	assign bus.irq = |(bus.status & bus.mask);

	a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
		bus.event_p[0] |=> bus.status[0])
		else $error("watch event lost against clear");
endmodule
`default_nettype wire

// *** logic/watch_interval_timer.sv ***
// Function
// - A 5-bit counter fed by the prescaler, started and stopped by the run bit.
// - An 11-bit prescaler divides the selected watch clock ahead of the counter.
// - The control register resets to zero on every reset, timer stopped.
// - The control register is fully readable and writable, byte or bit wise.
// - Bits 6:4 pick the interval; their value n gives 2^(4+n) watch clocks.
// - Bits 3:2 pick the watch period: 2^14, 2^13, 2^5 or 2^4 clocks.
// - Run bit one makes the counter count; zero stops and clears it.
// - Enable bit zero stops the count clock and clears prescaler and counter.
// - The control register gates clock and operation and holds the interval, watch period and clock source selections.
// - The 5-bit counter counts only when enable and run bits are both one; the prescaler needs the enable bit alone.
// - Separate watch and interval interrupts, which may fire together.
`timescale 1ns/10ps
`default_nettype none
module watch_interval_timer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sub_osc_clock,
	input wire logic div_main_clock,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [27:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic watch_irq,
	output logic interval_irq,
	output logic irq
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	irq_if ibus ();
	wit_pkg::bus_state_t bus_state;
	wit_pkg::bus_state_t next_bus_state;
	logic [31:0] next_dat;
	logic [7:0] watch_timer_control;
	logic [7:0] next_control;
	logic [10:0] prescale;
	logic [10:0] next_prescale;
	logic [4:0] count;
	logic [4:0] next_count;
	logic watch_ev;
	logic interval_ev;
	logic next_watch_irq;
	logic next_interval_irq;
	logic sub_rise;
	logic main_rise;
	logic watch_count_clock;
	logic timer_enable_bit;
	logic counter_run_bit;
	logic clock_source_bit;
	logic [2:0] interval_select_field;
	wit_pkg::flag_period_t flag_period_field;
	logic [10:0] ivl_mask;
	logic prescale_wrap;
	logic bus_commit;
	logic [11:0] ivl_ticks;
	logic [11:0] next_ivl_ticks;
	logic [11:0] ivl_period;
	logic [14:0] watch_ticks;
	logic [14:0] next_watch_ticks;
	logic [14:0] watch_period;
	logic watch_seen;
	logic next_watch_seen;

	// ----------------------------------------------------------------
	// Watch clock edges, both sources arrive from outside this domain
	// ----------------------------------------------------------------
	edge_sync sub_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(sub_osc_clock),
		.rise(sub_rise)
	);

	edge_sync main_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(div_main_clock),
		.rise(main_rise)
	);

	assign timer_enable_bit = watch_timer_control[wit_pkg::EN_BIT];
	assign counter_run_bit = watch_timer_control[wit_pkg::RUN_BIT];
	assign clock_source_bit = watch_timer_control[wit_pkg::SRC_BIT];
	assign interval_select_field = watch_timer_control[wit_pkg::IVL_LSB +: 3];
	assign flag_period_field = wit_pkg::flag_period_t'(watch_timer_control[wit_pkg::FLAG_LSB +: 2]);

	// Source switch is glitch-free only because software changes it while stopped
	assign watch_count_clock = timer_enable_bit
		& (clock_source_bit ? main_rise : sub_rise);

	// ----------------------------------------------------------------
	// Prescaler and 5-bit counter
	// ----------------------------------------------------------------
	assign prescale_wrap = (prescale == wit_pkg::PRESCALE_FULL);
	assign ivl_mask = wit_pkg::PRESCALE_FULL >> (3'h7 - interval_select_field);

	always_comb begin
		next_prescale = prescale;
		next_count = count;
		if (!timer_enable_bit) begin
			next_prescale = wit_pkg::PRESCALE_RESET;
		end else if (watch_count_clock) begin
			next_prescale = 11'(prescale + 11'h001);
		end
		if (!timer_enable_bit || !counter_run_bit) begin
			next_count = wit_pkg::COUNT_RESET;
		end else if (watch_count_clock && prescale_wrap) begin
			next_count = 5'(count + 5'h01);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prescale <= wit_pkg::PRESCALE_RESET;
			count <= wit_pkg::COUNT_RESET;
		end else begin
			prescale <= next_prescale;
			count <= next_count;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt events
	// ----------------------------------------------------------------
	always_comb begin
		interval_ev = watch_count_clock && ((prescale & ivl_mask) == ivl_mask);
		watch_ev = 1'b0;
		if (watch_count_clock && counter_run_bit) begin
			unique case (flag_period_field)
				wit_pkg::FLAG_2P14: watch_ev = prescale_wrap && (count[2:0] == 3'h7);
				wit_pkg::FLAG_2P13: watch_ev = prescale_wrap && (count[1:0] == 2'h3);
				wit_pkg::FLAG_2P5: watch_ev = (prescale[4:0] == 5'h1f);
				wit_pkg::FLAG_2P4: watch_ev = (prescale[3:0] == 4'hf);
			endcase
		end
		next_watch_irq = watch_ev;
		next_interval_irq = interval_ev;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			watch_irq <= 1'b0;
			interval_irq <= 1'b0;
		end else begin
			watch_irq <= next_watch_irq;
			interval_irq <= next_interval_irq;
		end
	end

	irq_ctl irq_block (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.bus(ibus)
	);

	assign ibus.event_p = {interval_ev, watch_ev};
	assign ibus.wdata = wb_dat_i[1:0];
	assign ibus.wr_status = bus_commit && wb_we_i && wb_sel_i[0]
		&& (wb_adr_i == wit_pkg::STATUS_ADDR);
	assign ibus.wr_mask = bus_commit && wb_we_i && wb_sel_i[0] && (wb_adr_i == wit_pkg::MASK_ADDR);
	assign irq = ibus.irq;

	// ----------------------------------------------------------------
	// Wishbone slave, one wait state, write lands on the acking edge
	// ----------------------------------------------------------------
	assign wb_ack_o = (bus_state == wit_pkg::BUS_ACK);
	assign bus_commit = wb_ack_o && wb_cyc_i && wb_stb_i;

	always_comb begin
		next_bus_state = bus_state;
		next_dat = wb_dat_o;
		next_control = watch_timer_control;
		unique case (bus_state)
			wit_pkg::BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					next_bus_state = wit_pkg::BUS_ACK;
					unique case (wb_adr_i)
						wit_pkg::CTRL_ADDR: next_dat = {24'h00_0000, watch_timer_control};
						wit_pkg::STATUS_ADDR: next_dat = {30'h0000_0000, ibus.status};
						wit_pkg::MASK_ADDR: next_dat = {30'h0000_0000, ibus.mask};
						default: next_dat = wit_pkg::UNMAPPED_DATA;
					endcase
				end
			end
			wit_pkg::BUS_ACK: begin
				next_bus_state = wit_pkg::BUS_IDLE;
			end
			default: begin
				next_bus_state = wit_pkg::BUS_IDLE;
			end
		endcase
		// Bit writes arrive as read-modify-write of the whole byte
		if (bus_commit && wb_we_i && wb_sel_i[0] && (wb_adr_i == wit_pkg::CTRL_ADDR)) begin
			next_control = wb_dat_i[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bus_state <= wit_pkg::BUS_IDLE;
			wb_dat_o <= wit_pkg::UNMAPPED_DATA;
			watch_timer_control <= wit_pkg::CTRL_RESET;
		end else begin
			bus_state <= next_bus_state;
			wb_dat_o <= next_dat;
			watch_timer_control <= next_control;
		end
	end

	// ----------------------------------------------------------------
	// Reference tick counts for the period checks
	// ----------------------------------------------------------------
	// Counted apart from the prescaler taps, so a wrong tap shows as a wrong period
	always_comb begin
		ivl_period = 12'h010 << interval_select_field;
		unique case (flag_period_field)
			wit_pkg::FLAG_2P14: watch_period = 15'h4000;
			wit_pkg::FLAG_2P13: watch_period = 15'h2000;
			wit_pkg::FLAG_2P5: watch_period = 15'h0020;
			wit_pkg::FLAG_2P4: watch_period = 15'h0010;
		endcase
		next_ivl_ticks = ivl_ticks;
		if (!timer_enable_bit || interval_irq) begin
			next_ivl_ticks = 12'h000;
		end else if (watch_count_clock) begin
			next_ivl_ticks = 12'(ivl_ticks + 12'h001);
		end
		next_watch_ticks = watch_ticks;
		next_watch_seen = watch_seen;
		if (!timer_enable_bit || !counter_run_bit) begin
			next_watch_ticks = 15'h0000;
			next_watch_seen = 1'b0;
		end else if (watch_irq) begin
			next_watch_ticks = 15'h0000;
			next_watch_seen = 1'b1;
		end else if (watch_count_clock) begin
			next_watch_ticks = 15'(watch_ticks + 15'h0001);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ivl_ticks <= 12'h000;
			watch_ticks <= 15'h0000;
			watch_seen <= 1'b0;
		end else begin
			ivl_ticks <= next_ivl_ticks;
			watch_ticks <= next_watch_ticks;
			watch_seen <= next_watch_seen;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_reset_clears_ctrl: assert property (disable iff (1'b0)
		!rst_n |=> watch_timer_control == wit_pkg::CTRL_RESET)
		else $error("control not cleared by reset");

	a_disable_clears_all: assert property (!timer_enable_bit |=>
		prescale == wit_pkg::PRESCALE_RESET && count == wit_pkg::COUNT_RESET)
		else $error("disable did not clear prescaler and counter");

	a_run_low_clears: assert property (!counter_run_bit |=> count == wit_pkg::COUNT_RESET)
		else $error("counter not cleared with run low");

	a_count_needs_both: assert property (count != $past(count) && count != wit_pkg::COUNT_RESET
		|-> $past(timer_enable_bit) && $past(counter_run_bit))
		else $error("counter moved without enable and run");

	a_prescale_steps: assert property (timer_enable_bit && watch_count_clock
		|=> prescale == 11'($past(prescale) + 11'h001))
		else $error("prescaler did not advance on a watch clock");

	a_counter_carry: assert property (timer_enable_bit && counter_run_bit && watch_count_clock
		&& prescale_wrap |=> count == 5'($past(count) + 5'h01))
		else $error("counter missed a prescaler carry");

	a_interval_cause: assert property (interval_irq |-> $past(watch_count_clock)
		&& (($past(prescale) & $past(ivl_mask)) == $past(ivl_mask)))
		else $error("interval pulse without its period");

	a_watch_short: assert property (watch_irq && $past(flag_period_field) == wit_pkg::FLAG_2P4
		|-> $past(prescale[3:0]) == 4'hf)
		else $error("watch pulse off its short period");

	a_pulse_single: assert property (watch_irq || interval_irq
		|=> !watch_irq && !interval_irq)
		else $error("interrupt pulse longer than one cycle");

	a_ctrl_write: assert property (bus_commit && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == wit_pkg::CTRL_ADDR |=> watch_timer_control == $past(wb_dat_i[7:0]))
		else $error("control write not stored");

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");

	a_interval_period: assert property (interval_irq |-> ivl_ticks == ivl_period)
		else $error("interval pulse off its period");

	a_interval_due: assert property (ivl_ticks <= ivl_period)
		else $error("interval pulse overdue");

	a_watch_period: assert property (watch_irq && watch_seen
		|-> watch_ticks == watch_period)
		else $error("watch pulse off its period");

	a_watch_due: assert property (watch_ticks <= watch_period)
		else $error("watch pulse overdue");

	c_interval_pulse: cover property (interval_irq);
	c_watch_pulse: cover property (watch_irq);
	c_both_pulses: cover property (watch_irq && interval_irq);
	c_divided_tick: cover property (clock_source_bit && watch_count_clock);
	c_ctrl_written: cover property (bus_commit && wb_we_i && wb_adr_i == wit_pkg::CTRL_ADDR);
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sub_osc_clock = 1'b0;
	logic div_main_clock = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [27:0] wb_adr_i = 28'h000_0000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic watch_irq;
	logic interval_irq;
	logic irq;
	logic [31:0] rd;
	int n_fail = 0;
	int total_checks = 0;
	int cnt_w = 0;
	int cnt_i = 0;
	int base_w = 0;
	int base_i = 0;
	logic [7:0] ctrl_now = 8'h00;

	watch_interval_timer dut_u (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.sub_osc_clock(sub_osc_clock),
		.div_main_clock(div_main_clock),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.watch_irq(watch_irq),
		.interval_irq(interval_irq),
		.irq(irq)
	);

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// Pulses last one cycle, so each sampled high level is one event
	always @(posedge core_clk) begin
		if (watch_irq === 1'b1) cnt_w <= cnt_w + 1;
		if (interval_irq === 1'b1) cnt_i <= cnt_i + 1;
	end

	// ----------------------------------------------------------------
	// Bench tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h", $time, msg, got);
		end
	endtask

	task automatic wb_xfer(input logic we, input logic [27:0] adr, input logic [31:0] dat,
			input logic [3:0] sel);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (wb_ack_o === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			$display("mismatch at %0t: bus wait ran out", $time);
			final_report();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [27:0] adr, input logic [7:0] v);
		wb_xfer(1'b1, adr, {24'h00_0000, v}, 4'h1);
	endtask

	task automatic rdc(input logic [27:0] adr, input logic [7:0] v, input string msg);
		wb_xfer(1'b0, adr, 32'h0000_0000, 4'hf);
		check(rd, {24'h00_0000, v}, msg);
	endtask

	// Slow clock kept far below a quarter of core_clk so the synchroniser sees every edge
	task automatic tick(input logic src, input int n);
		repeat (n) begin
			if (src) div_main_clock <= 1'b1;
			else sub_osc_clock <= 1'b1;
			repeat (8) @(posedge core_clk);
			sub_osc_clock <= 1'b0;
			div_main_clock <= 1'b0;
			repeat (8) @(posedge core_clk);
		end
		repeat (8) @(posedge core_clk);
	endtask

	task automatic run(input logic [7:0] c, input logic src, input int n, input int ew,
			input int ei, input string msg);
		wr(wit_pkg::CTRL_ADDR, ctrl_now & 8'hfc);
		wr(wit_pkg::CTRL_ADDR, c & 8'hfc);
		wr(wit_pkg::CTRL_ADDR, c);
		ctrl_now = c;
		base_w = cnt_w;
		base_i = cnt_i;
		tick(src, n);
		check(32'(cnt_w - base_w), 32'(ew), msg);
		check(32'(cnt_i - base_i), 32'(ei), msg);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rdc(wit_pkg::CTRL_ADDR, 8'h00, "ctrl reset");
		rdc(wit_pkg::STATUS_ADDR, 8'h00, "status reset");
		rdc(wit_pkg::MASK_ADDR, 8'h00, "mask reset");
		for (int b = 0; b < 8; b++) begin
			wr(wit_pkg::CTRL_ADDR, 8'h01 << b);
			rdc(wit_pkg::CTRL_ADDR, 8'h01 << b, "ctrl bit");
			wr(wit_pkg::CTRL_ADDR, 8'h00);
		end
		wr(wit_pkg::CTRL_ADDR, 8'h00);
		wb_xfer(1'b1, wit_pkg::CTRL_ADDR, 32'h0000_003c, 4'h0);
		rdc(wit_pkg::CTRL_ADDR, 8'h00, "sel0 low write");
		wr(28'hfff_f6fc, 8'hff);
		rdc(28'hfff_f6fc, 8'h00, "unmapped read");
		$display("test registers done");
		for (int n = 0; n < 8; n++) begin
			run({1'b0, 3'(n), 4'hf}, 1'b0, 2 ** (4 + n), 2 ** n, 1, "interval n");
		end
		run(8'h1b, 1'b0, 64, 2, 2, "flag 10 period");
		$display("test periods done");
		run(8'h0e, 1'b0, 32, 0, 0, "enable low");
		run(8'h8f, 1'b1, 32, 2, 2, "divided source");
		base_w = cnt_w;
		base_i = cnt_i;
		tick(1'b0, 32);
		check(32'(cnt_i - base_i), 32'h0000_0000, "sub clock ignored");
		check(32'(cnt_w - base_w), 32'h0000_0000, "sub clock ignored");
		$display("test sources done");
		rdc(wit_pkg::STATUS_ADDR, 8'h03, "both events");
		check({31'h0000_0000, irq}, 32'h0000_0000, "irq masked");
		wr(wit_pkg::MASK_ADDR, 8'h01);
		rdc(wit_pkg::MASK_ADDR, 8'h01, "mask rw");
		check({31'h0000_0000, irq}, 32'h0000_0001, "irq unmasked");
		wr(wit_pkg::STATUS_ADDR, 8'h01);
		rdc(wit_pkg::STATUS_ADDR, 8'h02, "w1c watch");
		check({31'h0000_0000, irq}, 32'h0000_0000, "irq after clear");
		wr(wit_pkg::MASK_ADDR, 8'h03);
		check({31'h0000_0000, irq}, 32'h0000_0001, "irq interval");
		wr(wit_pkg::STATUS_ADDR, 8'h03);
		rdc(wit_pkg::STATUS_ADDR, 8'h00, "w1c all");
		check({31'h0000_0000, irq}, 32'h0000_0000, "irq idle");
		$display("test interrupts done");
		wr(wit_pkg::CTRL_ADDR, ctrl_now & 8'hfc);
		wr(wit_pkg::CTRL_ADDR, 8'h3c);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		rdc(wit_pkg::CTRL_ADDR, 8'h00, "ctrl second reset");
		rdc(wit_pkg::MASK_ADDR, 8'h00, "mask second reset");
		$display("test reset done");
		final_report();
	end
endmodule
`default_nettype wire
